// File: hw/timer2_aux_sfr_bank.sv
// Timer 2 control, auxiliary and pointer-bank special registers
//
// How it works
// - Unmapped addresses read zero, writes there do nothing.
// - Timer 2 control resets to zero and accepts single-bit writes.
// - Overflow flag set per overflow, software clears, held off in baud mode.
// - Trigger capture or reload sets external flag, interrupt when enabled.
// - External flag raises no interrupt while down-count enable is set.
// - Receive clock taken from Timer 2 in serial modes 1 and 3.
// - Transmit clock taken from Timer 2 in serial modes 1 and 3.
// - Trigger edges act only when enabled and not in baud mode.
// - Run bit starts and stops Timer 2 counting.
// - Counter select picks machine ticks or external falling edges.
// - Capture select chooses capture on trigger or reload modes.
// - Baud mode ignores capture select and reloads on overflow.
// - Capture/reload pair takes captures and supplies reload value.
// - Auxiliary register byte-only, bits 0, 3, 4, reset zero.
// - Address strobe every sixth cycle, or only on external access.
// - Watchdog timeout drives reset pin high unless disabled.
// - Watchdog idle-halt bit pauses the watchdog during idle.
// - Bank select routes pointer use to first or second bank.
// - Power-loss flag set at power-up, writable, untouched by reset.
// - Interrupt enable and two-level priority for six sources.
// - Bank register byte-only, only bit 0 implemented, resets zero.
`timescale 1ns/10ps
module timer2_aux_sfr_bank
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic        power_up_in,
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic        sfr_wr_in,
  input  wire logic [7:0]  sfr_wdata_in,
  input  wire logic        sfr_bit_wr_in,
  input  wire logic [2:0]  sfr_bit_pos_in,
  input  wire logic        sfr_bit_val_in,
  input  wire logic        sfr_rd_in,
  output logic [7:0]       sfr_rdata_out,
  input  wire logic        timer2_overflow_in,
  input  wire logic [15:0] timer2_count_in,
  input  wire logic        trigger_input_in,
  input  wire logic        external_count_input_in,
  input  wire logic [1:0]  serial_mode_in,
  input  wire logic        ext_access_in,
  input  wire logic        idle_in,
  input  wire logic        watchdog_timeout_in,
  output logic             timer2_run_out,
  output logic             count_pulse_out,
  output logic             capture_out,
  output logic             reload_out,
  output logic [15:0]      capture_reload_out,
  output logic             rx_from_timer2_out,
  output logic             tx_from_timer2_out,
  output logic             timer2_irq_out,
  output logic [7:0]       irq_enable_out,
  output logic [5:0]       priority_out,
  output logic             address_strobe_out,
  output logic             reset_pin_out,
  output logic             reset_pin_oe_out,
  output logic             watchdog_count_en_out,
  output logic             pointer_bank_select_out,
  output logic [15:0]      active_pointer_out
);
  logic [7:0] t2_q;
  logic [7:0] aux_q;
  logic [7:0] bank_q;
  logic [7:0] mode_q;
  logic [7:0] cr_lo_q;
  logic [7:0] cr_hi_q;
  logic       power_loss_q;
  logic [7:0] t2_wdata;
  logic       wr_t2;
  logic       baud;
  logic       trig_fall;
  logic       cnt_fall;
  logic       trig_evt;
  logic       ovf_ok;
  logic       is_ptr;
  logic       rd_q;
  logic       rd_ptr_q;
  logic [7:0] own_q;
  logic [2:0] div_q;
  logic [6:0] rst_cnt_q;

  pointer_bank_if ptr ();

  //////////////////////////////////////////////////////////////////////
  // Pin inputs
  edge_sense trig_sense
  (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .pin_in     (trigger_input_in),
    .fall_out   (trig_fall)
  );

  edge_sense count_sense
  (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .pin_in     (external_count_input_in),
    .fall_out   (cnt_fall)
  );

  //////////////////////////////////////////////////////////////////////
  // Write decode
  // Bit writes only reach the bit-addressable control register
  always_comb
  begin
    t2_wdata = sfr_wdata_in;
    if (sfr_bit_wr_in)
    begin
      t2_wdata = t2_q;
      t2_wdata[sfr_bit_pos_in] = sfr_bit_val_in;
    end
  end

  assign wr_t2 = (sfr_wr_in | sfr_bit_wr_in)
               & (sfr_addr_in == sfr_bank_pkg::ADDR_T2_CTL);
  assign baud  = t2_q[sfr_bank_pkg::T2_RXCLK] | t2_q[sfr_bank_pkg::T2_TXCLK];
  assign ovf_ok = timer2_overflow_in & ~baud;
  assign trig_evt = trig_fall & t2_q[sfr_bank_pkg::T2_TRGEN] & ~baud;
  assign is_ptr = sfr_addr_in[7:1] == sfr_bank_pkg::ADDR_SECOND_LO[7:1]
                | sfr_addr_in[7:1] == sfr_bank_pkg::ADDR_FIRST_LO[7:1];

  //////////////////////////////////////////////////////////////////////
  // Timer 2 control; hardware set wins over a software clear
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      t2_q <= sfr_bank_pkg::T2_RST;
    else
    begin
      if (wr_t2)
        t2_q <= t2_wdata;
      if (ovf_ok)
        t2_q[sfr_bank_pkg::T2_OVF] <= 1'b1;
      if (trig_evt)
        t2_q[sfr_bank_pkg::T2_EXT] <= 1'b1;
    end
  end

  // Auxiliary, bank, mode, enable and priority registers, byte writes only
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      aux_q          <= sfr_bank_pkg::AUX_RST;
      bank_q         <= sfr_bank_pkg::BANK_RST;
      mode_q         <= sfr_bank_pkg::MODE_RST;
      irq_enable_out <= sfr_bank_pkg::IE_RST;
      priority_out   <= sfr_bank_pkg::IP_RST[5:0];
    end
    else if (sfr_wr_in)
    begin
      if (sfr_addr_in == sfr_bank_pkg::ADDR_AUX)
        aux_q <= sfr_wdata_in & sfr_bank_pkg::AUX_MASK;
      else if (sfr_addr_in == sfr_bank_pkg::ADDR_BANK)
        bank_q <= sfr_wdata_in & sfr_bank_pkg::BANK_MASK;
      else if (sfr_addr_in == sfr_bank_pkg::ADDR_T2_MODE)
        mode_q <= sfr_wdata_in & sfr_bank_pkg::MODE_MASK;
      else if (sfr_addr_in == sfr_bank_pkg::ADDR_IRQ_EN)
        irq_enable_out <= sfr_wdata_in & sfr_bank_pkg::IE_MASK;
      else if (sfr_addr_in == sfr_bank_pkg::ADDR_PRIO)
        priority_out <= sfr_wdata_in[5:0];
    end
  end

  // Capture/reload pair; a capture outranks a same-cycle CPU write
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      cr_lo_q <= sfr_bank_pkg::CR_RST;
      cr_hi_q <= sfr_bank_pkg::CR_RST;
    end
    else if (trig_evt & t2_q[sfr_bank_pkg::T2_CPRL])
    begin
      cr_lo_q <= timer2_count_in[7:0];
      cr_hi_q <= timer2_count_in[15:8];
    end
    else if (sfr_wr_in & sfr_addr_in == sfr_bank_pkg::ADDR_CR_LO)
      cr_lo_q <= sfr_wdata_in;
    else if (sfr_wr_in & sfr_addr_in == sfr_bank_pkg::ADDR_CR_HI)
      cr_hi_q <= sfr_wdata_in;
  end

  // No reset term: only power-up or software moves this flag
  always_ff @(posedge ref_clk_in)
  begin
    if (power_up_in)
      power_loss_q <= 1'b1;
    else if (sfr_wr_in & sfr_addr_in == sfr_bank_pkg::ADDR_POWER)
      power_loss_q <= sfr_wdata_in[sfr_bank_pkg::PWR_LOSS];
  end

  //////////////////////////////////////////////////////////////////////
  // Timer 2 event outputs
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      count_pulse_out    <= 1'b0;
      capture_out        <= 1'b0;
      reload_out         <= 1'b0;
      rx_from_timer2_out <= 1'b0;
      tx_from_timer2_out <= 1'b0;
      timer2_irq_out     <= 1'b0;
    end
    else
    begin
      count_pulse_out <= t2_q[sfr_bank_pkg::T2_RUN]
        & (t2_q[sfr_bank_pkg::T2_CNT] ? cnt_fall : 1'b1);
      capture_out <= trig_evt & t2_q[sfr_bank_pkg::T2_CPRL];
      reload_out <= (trig_evt & ~t2_q[sfr_bank_pkg::T2_CPRL])
        | (timer2_overflow_in
           & (baud | ~t2_q[sfr_bank_pkg::T2_CPRL]));
      rx_from_timer2_out <= t2_q[sfr_bank_pkg::T2_RXCLK]
        & serial_mode_in[0];
      tx_from_timer2_out <= t2_q[sfr_bank_pkg::T2_TXCLK]
        & serial_mode_in[0];
      timer2_irq_out <= irq_enable_out[sfr_bank_pkg::IE_ALL]
        & irq_enable_out[sfr_bank_pkg::IE_T2]
        & (t2_q[sfr_bank_pkg::T2_OVF]
           | (t2_q[sfr_bank_pkg::T2_EXT]
              & ~mode_q[sfr_bank_pkg::MODE_DOWN]));
    end
  end

  assign timer2_run_out     = t2_q[sfr_bank_pkg::T2_RUN];
  assign capture_reload_out = {cr_hi_q, cr_lo_q};

  //////////////////////////////////////////////////////////////////////
  // Address strobe, reset pin and watchdog gating
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      div_q              <= '0;
      address_strobe_out <= 1'b0;
    end
    else
    begin
      div_q <= (div_q == 3'(sfr_bank_pkg::STROBE_DIV - 1))
             ? '0 : div_q + 3'd1;
      address_strobe_out <= aux_q[sfr_bank_pkg::AUX_STRB]
        ? ext_access_in : (div_q == '0);
    end
  end

  // A timeout during an active pulse restarts the full width
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      rst_cnt_q <= '0;
    else if (watchdog_timeout_in & ~aux_q[sfr_bank_pkg::AUX_RSTO])
      rst_cnt_q <= 7'(sfr_bank_pkg::RST_OUT_CYC);
    else if (rst_cnt_q != '0)
      rst_cnt_q <= rst_cnt_q - 7'd1;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      reset_pin_out         <= 1'b0;
      reset_pin_oe_out      <= 1'b0;
      watchdog_count_en_out <= 1'b1;
    end
    else
    begin
      reset_pin_out    <= rst_cnt_q != '0;
      reset_pin_oe_out <= rst_cnt_q != '0;
      watchdog_count_en_out <= ~(idle_in
        & aux_q[sfr_bank_pkg::AUX_WDIH]);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pointer banks
  assign ptr.wr    = sfr_wr_in & is_ptr;
  assign ptr.idx   = sfr_addr_in[2:1] == 2'b01 ? {1'b0, sfr_addr_in[0]}
                                               : {1'b1, sfr_addr_in[0]};
  assign ptr.wdata = sfr_wdata_in;
  assign ptr.bank  = bank_q[sfr_bank_pkg::BANK_SEL];

  pointer_store banks
  (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .port       (ptr)
  );

  assign pointer_bank_select_out = bank_q[sfr_bank_pkg::BANK_SEL];
  assign active_pointer_out      = ptr.active;

  //////////////////////////////////////////////////////////////////////
  // Read path, two cycles to match the pointer store
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      rd_q     <= 1'b0;
      rd_ptr_q <= 1'b0;
      own_q    <= '0;
    end
    else
    begin
      rd_q     <= sfr_rd_in;
      rd_ptr_q <= is_ptr;
      if (sfr_addr_in == sfr_bank_pkg::ADDR_T2_CTL)
        own_q <= t2_q;
      else if (sfr_addr_in == sfr_bank_pkg::ADDR_AUX)
        own_q <= aux_q;
      else if (sfr_addr_in == sfr_bank_pkg::ADDR_BANK)
        own_q <= bank_q;
      else if (sfr_addr_in == sfr_bank_pkg::ADDR_T2_MODE)
        own_q <= mode_q;
      else if (sfr_addr_in == sfr_bank_pkg::ADDR_CR_LO)
        own_q <= cr_lo_q;
      else if (sfr_addr_in == sfr_bank_pkg::ADDR_CR_HI)
        own_q <= cr_hi_q;
      else if (sfr_addr_in == sfr_bank_pkg::ADDR_IRQ_EN)
        own_q <= irq_enable_out;
      else if (sfr_addr_in == sfr_bank_pkg::ADDR_PRIO)
        own_q <= {2'b00, priority_out};
      else if (sfr_addr_in == sfr_bank_pkg::ADDR_POWER)
        own_q <= {3'b000, power_loss_q, 4'h0};
      else
        own_q <= '0;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      sfr_rdata_out <= '0;
    else if (rd_q)
      sfr_rdata_out <= rd_ptr_q ? ptr.rdata : own_q;
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  chk_ovf_flag_set: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) ovf_ok |=> t2_q[sfr_bank_pkg::T2_OVF])
    else $error("overflow flag not set");
  chk_ovf_baud_hold: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) baud & ~wr_t2 & ~t2_q[sfr_bank_pkg::T2_OVF]
    |=> ~t2_q[sfr_bank_pkg::T2_OVF])
    else $error("overflow flag set in baud mode");
  chk_ext_flag_set: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) trig_evt |=> t2_q[sfr_bank_pkg::T2_EXT])
    else $error("external flag not set");
  chk_down_no_irq: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) mode_q[sfr_bank_pkg::MODE_DOWN]
    & ~t2_q[sfr_bank_pkg::T2_OVF] & $stable(mode_q) |=> ~timer2_irq_out)
    else $error("interrupt from external flag in down mode");
  chk_trig_ignored: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) ~t2_q[sfr_bank_pkg::T2_TRGEN] |=> ~capture_out)
    else $error("capture without trigger enable");
  chk_capture_value: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) capture_out
    |-> capture_reload_out == $past(timer2_count_in))
    else $error("capture value wrong");
  chk_aux_reserved: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) (aux_q & ~sfr_bank_pkg::AUX_MASK) == 8'h00)
    else $error("reserved auxiliary bit set");
  chk_strobe_rate: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) address_strobe_out
    & ~aux_q[sfr_bank_pkg::AUX_STRB] & $stable(aux_q)
    |=> ~address_strobe_out [*5])
    else $error("strobe rate wrong");
  chk_reset_pulse: assert property (@(posedge ref_clk_in)
    disable iff (reset_in) watchdog_timeout_in
    & ~aux_q[sfr_bank_pkg::AUX_RSTO] |=> ##1 reset_pin_oe_out [*8])
    else $error("reset pin not driven");
  chk_power_hold: assert property (@(posedge ref_clk_in)
    reset_in & ~power_up_in & ~sfr_wr_in |=> $stable(power_loss_q))
    else $error("power-loss flag moved by reset");
endmodule

// File: hw/sfr_bank_pkg.sv
// Shared addresses, field positions, reset values and timing counts
package sfr_bank_pkg;
  // Special register space addresses
  localparam logic [7:0] ADDR_FIRST_LO  = 8'h82;
  localparam logic [7:0] ADDR_FIRST_HI  = 8'h83;
  localparam logic [7:0] ADDR_SECOND_LO = 8'h84;
  localparam logic [7:0] ADDR_SECOND_HI = 8'h85;
  localparam logic [7:0] ADDR_POWER     = 8'h87;
  localparam logic [7:0] ADDR_AUX       = 8'h8e;
  localparam logic [7:0] ADDR_BANK      = 8'ha2;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'ha8;
  localparam logic [7:0] ADDR_PRIO      = 8'hb8;
  localparam logic [7:0] ADDR_T2_CTL    = 8'hc8;
  localparam logic [7:0] ADDR_T2_MODE   = 8'hc9;
  localparam logic [7:0] ADDR_CR_LO     = 8'hca;
  localparam logic [7:0] ADDR_CR_HI     = 8'hcb;
  // Timer 2 control fields
  localparam int T2_OVF   = 7;
  localparam int T2_EXT   = 6;
  localparam int T2_RXCLK = 5;
  localparam int T2_TXCLK = 4;
  localparam int T2_TRGEN = 3;
  localparam int T2_RUN   = 2;
  localparam int T2_CNT   = 1;
  localparam int T2_CPRL  = 0;
  // Auxiliary, bank, power, mode and enable fields
  localparam int AUX_STRB  = 0;
  localparam int AUX_RSTO  = 3;
  localparam int AUX_WDIH  = 4;
  localparam int BANK_SEL  = 0;
  localparam int PWR_LOSS  = 4;
  localparam int MODE_DOWN = 0;
  localparam int IE_ALL    = 7;
  localparam int IE_T2     = 5;
  // Implemented-bit masks
  localparam logic [7:0] AUX_MASK  = 8'h19;
  localparam logic [7:0] BANK_MASK = 8'h01;
  localparam logic [7:0] MODE_MASK = 8'h03;
  localparam logic [7:0] IE_MASK   = 8'hbf;
  localparam logic [7:0] IP_MASK   = 8'h3f;
  // Reset values
  localparam logic [7:0] T2_RST   = 8'h00;
  localparam logic [7:0] AUX_RST  = 8'h00;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] IE_RST   = 8'h00;
  localparam logic [7:0] IP_RST   = 8'h00;
  localparam logic [7:0] CR_RST   = 8'h00;
  localparam logic [7:0] PTR_RST  = 8'h00;
  // Timing: the clock stands in for the oscillator
  localparam int CLK_PERIOD_NS = 20;
  localparam int STROBE_DIV    = 6;
  localparam int RST_OUT_NS    = 1920;
  localparam int RST_OUT_CYC   = RST_OUT_NS / CLK_PERIOD_NS;
endpackage

// File: hw/pointer_bank_if.sv
// Carrier between the register bank and the pointer store
`timescale 1ns/10ps
interface pointer_bank_if;
  logic        wr;
  logic [1:0]  idx;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        bank;
  logic [15:0] active;
  modport ctrl (output wr, idx, wdata, bank, input rdata, active);
  modport store (input wr, idx, wdata, bank, output rdata, active);
endinterface

// File: hw/pointer_store.sv
// Two 16-bit data pointer banks with registered read data
`timescale 1ns/10ps
module pointer_store
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  pointer_bank_if.store    port
);
  logic [7:0] mem_q [4];

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < 4; i++)
        mem_q[i] <= sfr_bank_pkg::PTR_RST;
    end
    else if (port.wr)
      mem_q[port.idx] <= port.wdata;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      port.rdata  <= sfr_bank_pkg::PTR_RST;
      port.active <= {sfr_bank_pkg::PTR_RST, sfr_bank_pkg::PTR_RST};
    end
    else
    begin
      port.rdata  <= mem_q[port.idx];
      port.active <= port.bank ? {mem_q[3], mem_q[2]}
                               : {mem_q[1], mem_q[0]};
    end
  end
endmodule

// File: hw/edge_sense.sv
// Pin synchroniser with a falling-edge pulse
`timescale 1ns/10ps
module edge_sense
(
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  input  wire logic pin_in,
  output logic      fall_out
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // Reset to high so a pin held low after reset is taken as a falling edge
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign fall_out = last_q & ~sync_q;
endmodule

// File: sim/sfr_cpu_model.sv
// Processor-side model issuing special register accesses
`timescale 1ns/10ps
module sfr_cpu_model
(
  input  wire logic       ref_clk_in,
  output logic [7:0]      addr_out,
  output logic            wr_out,
  output logic [7:0]      wdata_out,
  output logic            bit_wr_out,
  output logic [2:0]      bit_pos_out,
  output logic            bit_val_out,
  output logic            rd_out,
  input  wire logic [7:0] rdata_in
);
  initial
  begin
    addr_out    = 8'h00;
    wr_out      = 1'b0;
    wdata_out   = 8'h00;
    bit_wr_out  = 1'b0;
    bit_pos_out = 3'h0;
    bit_val_out = 1'b0;
    rd_out      = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks start just after a falling edge; released lines show the inverse
  // of their last value, except the bit position, so a stale match cannot pass unnoticed. Writes rest
  // one cycle after release so no strobe is driven twice in one time step
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge ref_clk_in);
    wr_out    = 1'b0;
    addr_out  = ~a;
    wdata_out = ~d;
    @(negedge ref_clk_in);
  endtask

  task automatic write_bit(input logic [7:0] a, input logic [2:0] p,
                           input logic v);
    addr_out    = a;
    bit_pos_out = p;
    bit_val_out = v;
    bit_wr_out  = 1'b1;
    @(negedge ref_clk_in);
    bit_wr_out  = 1'b0;
    addr_out    = ~a;
    bit_val_out = ~v;
    @(negedge ref_clk_in);
  endtask

  // Read data lands one edge after the request edge
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    addr_out = a;
    rd_out   = 1'b1;
    @(negedge ref_clk_in);
    rd_out   = 1'b0;
    addr_out = ~a;
    @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    d = rdata_in;
  endtask
endmodule

// File: sim/timer2_aux_sfr_bank_bench.sv
// Self-checking bench for the Timer 2 and auxiliary register bank
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
  n_fail++; $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module timer2_aux_sfr_bank_bench;
  logic        ref_clk_in;
  logic        reset_in;
  logic        power_up_in;
  logic [7:0]  addr;
  logic        wr;
  logic [7:0]  wdata;
  logic        bit_wr;
  logic [2:0]  bit_pos;
  logic        bit_val;
  logic        rd;
  logic [7:0]  rdata;
  logic        ovf;
  logic [15:0] count;
  logic        trig;
  logic        ext_cnt;
  logic [1:0]  ser_mode;
  logic        ext_acc;
  logic        idle;
  logic        wd_to;
  logic        cnt_p;
  logic        cap;
  logic        rel;
  logic        rx_t2;
  logic        tx_t2;
  logic        irq;
  logic        strb;
  logic        rpin;
  logic        rpin_oe;
  logic        wd_en;
  logic        run;
  logic        bsel;
  logic [7:0]  ie;
  logic [5:0]  prio;
  logic [15:0] pair;
  logic [15:0] ptr;
  int          n_fail;
  int          tests_run;
  int          n_cap;
  int          n_rel;
  int          n_strb;
  int          n_rpin;
  int          n_cnt;

  sfr_cpu_model u_cpu (.ref_clk_in(ref_clk_in), .addr_out(addr),
    .wr_out(wr), .wdata_out(wdata), .bit_wr_out(bit_wr),
    .bit_pos_out(bit_pos), .bit_val_out(bit_val), .rd_out(rd),
    .rdata_in(rdata));

  timer2_aux_sfr_bank u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .power_up_in(power_up_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_wdata_in(wdata), .sfr_bit_wr_in(bit_wr), .sfr_bit_pos_in(bit_pos),
    .sfr_bit_val_in(bit_val), .sfr_rd_in(rd), .sfr_rdata_out(rdata),
    .timer2_overflow_in(ovf), .timer2_count_in(count),
    .trigger_input_in(trig), .external_count_input_in(ext_cnt),
    .serial_mode_in(ser_mode), .ext_access_in(ext_acc), .idle_in(idle),
    .watchdog_timeout_in(wd_to), .timer2_run_out(run),
    .count_pulse_out(cnt_p), .capture_out(cap), .reload_out(rel),
    .capture_reload_out(pair), .rx_from_timer2_out(rx_t2),
    .tx_from_timer2_out(tx_t2), .timer2_irq_out(irq),
    .irq_enable_out(ie), .priority_out(prio), .address_strobe_out(strb),
    .reset_pin_out(rpin), .reset_pin_oe_out(rpin_oe),
    .watchdog_count_en_out(wd_en), .pointer_bank_select_out(bsel),
    .active_pointer_out(ptr));

  ////////////////////////////////////////////////////////////////////////////
  initial ref_clk_in = 1'b0;
  always #10 ref_clk_in = ~ref_clk_in;

  // Pulse tallies let checks ignore exact output latency
  always @(posedge ref_clk_in)
  begin
    if (cap === 1'b1) n_cap++;
    if (rel === 1'b1) n_rel++;
    if (strb === 1'b1) n_strb++;
    if ((rpin & rpin_oe) === 1'b1) n_rpin++;
    if (cnt_p === 1'b1) n_cnt++;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  task automatic clr;
    n_cap  = 0;
    n_rel  = 0;
    n_strb = 0;
    n_rpin = 0;
    n_cnt  = 0;
  endtask

  task automatic wb(input logic [7:0] a, input logic [7:0] d);
    u_cpu.write_byte(a, d);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [7:0] ex);
    logic [7:0] d;
    u_cpu.read_byte(a, d);
    `CHK(nm, ex, d)
  endtask

  task automatic fall;
    trig = 1'b0;
    cyc(6);
    trig = 1'b1;
    cyc(6);
  endtask

  task automatic pulse_ovf;
    ovf = 1'b1;
    cyc(1);
    ovf = 1'b0;
    cyc(3);
  endtask

  task close_out;
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge ref_clk_in);
    n_fail++;
    close_out();
  end

  initial
  begin
    {ovf, ext_acc, idle, wd_to, ser_mode, count} = '0;
    {trig, ext_cnt, reset_in, power_up_in} = 4'hf;
    n_fail = 0;
    tests_run = 0;
    clr();
    cyc(12);
    reset_in = 1'b0;
    power_up_in = 1'b0;
    rchk("t2 reset", 8'hc8, 8'h00);
    rchk("aux reset", 8'h8e, 8'h00);
    rchk("bank reset", 8'ha2, 8'h00);
    rchk("power flag", 8'h87, 8'h10);
    wb(8'h87, 8'h00);
    rchk("power clear", 8'h87, 8'h00);
    wb(8'h87, 8'h10);
    reset_in = 1'b1;
    cyc(3);
    reset_in = 1'b0;
    rchk("power kept", 8'h87, 8'h10);
    wb(8'h8e, 8'hff);
    rchk("aux mask", 8'h8e, 8'h19);
    u_cpu.write_bit(8'h8e, 3'h0, 1'b0);
    rchk("aux no bit", 8'h8e, 8'h19);
    wb(8'ha2, 8'hff);
    rchk("bank mask", 8'ha2, 8'h01);
    wb(8'h8f, 8'h00);
    rchk("unmapped", 8'h8f, 8'h00);
    idle = 1'b1;
    cyc(3);
    `CHK("wd halted", 1'b0, wd_en)
    wb(8'h8e, 8'h00);
    cyc(3);
    `CHK("wd counts", 1'b1, wd_en)
    idle = 1'b0;
    clr();
    cyc(60);
    `CHK("strobe rate", 10, n_strb)
    wb(8'h8e, 8'h01);
    cyc(2);
    clr();
    cyc(30);
    `CHK("strobe off", 0, n_strb)
    ext_acc = 1'b1;
    cyc(3);
    clr();
    cyc(10);
    `CHK("strobe ext", 10, n_strb)
    ext_acc = 1'b0;
    cyc(3);
    clr();
    wd_to = 1'b1;
    cyc(1);
    wd_to = 1'b0;
    cyc(110);
    `CHK("reset out", sfr_bank_pkg::RST_OUT_CYC, n_rpin)
    wb(8'h8e, 8'h08);
    clr();
    wd_to = 1'b1;
    cyc(1);
    wd_to = 1'b0;
    cyc(110);
    `CHK("reset in only", 0, n_rpin)
    wb(8'ha2, 8'h00);
    wb(8'h82, 8'h34);
    wb(8'h83, 8'h12);
    wb(8'ha2, 8'h01);
    wb(8'h84, 8'h78);
    wb(8'h85, 8'h56);
    cyc(2);
    `CHK("second bank", 16'h5678, ptr)
    `CHK("bank sel", 1'b1, bsel)
    wb(8'ha2, 8'h00);
    cyc(2);
    `CHK("first bank", 16'h1234, ptr)
    rchk("ptr read", 8'h85, 8'h56);
    rchk("gap read", 8'h86, 8'h00);
    u_cpu.write_bit(8'hc8, 3'h2, 1'b1);
    cyc(2);
    `CHK("run", 1'b1, run)
    clr();
    cyc(10);
    `CHK("timer ticks", 10, n_cnt)
    u_cpu.write_bit(8'hc8, 3'h1, 1'b1);
    cyc(3);
    clr();
    cyc(10);
    `CHK("counter idle", 0, n_cnt)
    ext_cnt = 1'b0;
    cyc(6);
    ext_cnt = 1'b1;
    cyc(6);
    `CHK("counter edge", 1, n_cnt)
    wb(8'hc8, 8'h00);
    cyc(3);
    clr();
    cyc(5);
    `CHK("stopped", 0, n_cnt)
    pulse_ovf();
    `CHK("reload ovf", 1, n_rel)
    rchk("ovf flag", 8'hc8, 8'h80);
    wb(8'ha8, 8'ha0);
    cyc(3);
    `CHK("irq en", 8'ha0, ie)
    `CHK("ovf irq", 1'b1, irq)
    wb(8'hb8, 8'hff);
    cyc(2);
    `CHK("priority", 6'h3f, prio)
    wb(8'hc8, 8'h21);
    ser_mode = 2'h1;
    cyc(3);
    `CHK("rx clk", 1'b1, rx_t2)
    `CHK("tx clk off", 1'b0, tx_t2)
    `CHK("irq cleared", 1'b0, irq)
    clr();
    pulse_ovf();
    `CHK("baud reload", 1, n_rel)
    rchk("baud no flag", 8'hc8, 8'h21);
    wb(8'hc8, 8'h19);
    clr();
    fall();
    `CHK("baud trig", 0, n_cap + n_rel)
    `CHK("tx clk", 1'b1, tx_t2)
    ser_mode = 2'h2;
    cyc(3);
    `CHK("tx mode 2", 1'b0, tx_t2)
    count = 16'hbeef;
    wb(8'hc8, 8'h09);
    clr();
    fall();
    `CHK("capture", 1, n_cap)
    `CHK("pair", 16'hbeef, pair)
    rchk("ext flag", 8'hc8, 8'h49);
    `CHK("ext irq", 1'b1, irq)
    rchk("pair low", 8'hca, 8'hef);
    rchk("pair high", 8'hcb, 8'hbe);
    wb(8'hc9, 8'h01);
    cyc(3);
    `CHK("down no irq", 1'b0, irq)
    wb(8'hc9, 8'h00);
    wb(8'hc8, 8'h01);
    clr();
    fall();
    `CHK("trig off", 0, n_cap)
    rchk("no ext flag", 8'hc8, 8'h01);
    wb(8'hc8, 8'h08);
    clr();
    fall();
    `CHK("trig reload", 1, n_rel)
    rchk("reload flag", 8'hc8, 8'h48);
    close_out();
  end
endmodule
